// *** ccs_clock_partner.sv ***
// Behavioural model of the external reference clock and the on-chip oscillator.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_partner (
	// Control from the bench.
	input wire logic run,
	input wire logic hold_level,
	// Clocks towards the device.
	output logic ext_clk,
	output logic osc_clk
);
	// ----------------------------------------
	// Clock sources
	// ----------------------------------------
	// The external source toggles while run is high; parking it lets the bench read exact pin levels.
	initial ext_clk = 1'b0;
	always #40 ext_clk = run ? ~ext_clk : hold_level;
	// The oscillator parks at the inverse level so the two sources can be told apart.
	initial osc_clk = 1'b0;
	always #150 osc_clk = run ? ~osc_clk : ~hold_level;
endmodule
`default_nettype wire

// *** ccs_debug_clock_output_mux.sv ***
// Registered selector of the clock level shown on the debug pin.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
module ccs_debug_clock_output_mux
	import ccs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Selection and candidate levels.
	input wire ccs_pkg::ccs_src_t src,
	input wire logic [3:0] levels,
	// Selected level.
	output logic level_q
);
	// ------------------------------------------------------------
	// Selection.
	// ------------------------------------------------------------
	// A registered pick keeps mux glitches off the pin when the field changes.
	wire logic next_level = levels[src];

	always_ff @(posedge clk) begin
		if (rst) begin
			level_q <= 1'b0;
		end else begin
			level_q <= next_level;
		end
	end
endmodule
`default_nettype wire

// *** ccs_params.svh ***
// Constants for the clock source select and debug clock output block.
// Functional notes
// - Debug clock pin carries the clock picked by the source field.
// - Slew control register at index 0x1C16 steers the debug pin slew.
// - Disable bit set floats the debug clock pin.
// - Pin driven from reset until boot starts; boot then sets disable bit.
// - Select strap low: oscillator runs timer and generator, external input ignored.
// - Select strap high: external input feeds generator, oscillator runs timer only.
// - Boot with external reference bypasses PLL, assuming 11.2896, 12 or 12.288 MHz.
// - Boot sets SPI 500 kHz, I2C 400 kHz, UART 57600 baud from that reference.
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ------------------------------------------------------------
// Register indexes; byte address is four times the index.
// ------------------------------------------------------------
`define CCS_IDX_SLEW 16'h1C16
`define CCS_IDX_SRC 16'h1C17
`define CCS_IDX_ST3 16'h1C18
`define CCS_IDX_BOOT 16'h1C19
`define CCS_ADDR_SLEW (`CCS_IDX_SLEW << 2)
`define CCS_ADDR_SRC (`CCS_IDX_SRC << 2)
`define CCS_ADDR_ST3 (`CCS_IDX_ST3 << 2)
`define CCS_ADDR_BOOT (`CCS_IDX_BOOT << 2)

// ------------------------------------------------------------
// Field positions and reset values.
// ------------------------------------------------------------
`define CCS_DIS_BIT 0
`define CCS_BYP_BIT 4
`define CCS_STRAP_BIT 5
`define CCS_SLEW_RST 16'h0000
`define CCS_SRC_RST 2'h0
`define CCS_REFIDX_RST 2'h1
`define CCS_SRC_REF 2'h0
`define CCS_SRC_OSC 2'h1
`define CCS_SRC_DIV2 2'h2
`define CCS_SRC_DIV4 2'h3

// ------------------------------------------------------------
// Assumed boot reference frequencies and target rates.
// ------------------------------------------------------------
`define CCS_REF0_HZ 32'd11289600
`define CCS_REF1_HZ 32'd12000000
`define CCS_REF2_HZ 32'd12288000
`define CCS_SPI_HZ 32'd500000
`define CCS_I2C_HZ 32'd400000
`define CCS_UART_BAUD 32'd57600

`endif

// *** ccs_pkg.sv ***
// Types shared by the clock source select block.
package ccs_pkg;
	// Control sequence, Gray coded along reset, capture, boot, run.
	typedef enum logic [1:0] {
		CCS_ST_RESET = 2'b00,
		CCS_ST_CAPTURE = 2'b01,
		CCS_ST_BOOT = 2'b11,
		CCS_ST_RUN = 2'b10
	} ccs_state_e;
	typedef logic [1:0] ccs_src_t;
	typedef logic [7:0] ccs_div_t;
endpackage

// *** ccs_top.sv ***
// Clock source selection, boot clock setup and debug clock output with APB registers.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
module ccs_top
	import ccs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Board pins and oscillator.
	input wire logic clock_source_select,
	input wire logic external_reference_clock_in,
	input wire logic osc_32k_in,
	// Boot sequencer start pulse.
	input wire logic boot_start,
	// Debug clock pin.
	output logic debug_clock_output,
	output logic debug_clock_output_oe,
	output logic [15:0] clock_out_slew_control_o,
	// Clock generator and timer references.
	output logic gen_reference,
	output logic rtc_reference,
	output logic pll_bypass,
	// Boot serial settings.
	output ccs_pkg::ccs_div_t spi_divider,
	output ccs_pkg::ccs_div_t i2c_divider,
	output ccs_pkg::ccs_div_t uart_divider
);
	import ccs_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------
	logic sel_s1, sel_s2, ext_s1, ext_s2, osc_s1, osc_s2;

	// Pins come from outside this clock; only the second stage is read.
	always_ff @(posedge clk) begin
		sel_s1 <= clock_source_select;
		sel_s2 <= sel_s1;
		ext_s1 <= external_reference_clock_in;
		ext_s2 <= ext_s1;
		osc_s1 <= osc_32k_in;
		osc_s2 <= osc_s1;
	end

	// ------------------------------------------------------------
	// Control sequence and strap capture.
	// ------------------------------------------------------------
	ccs_state_e state, next_state;
	logic strap;

	// The strap is sampled once after reset, since the board keeps it fixed.
	always_comb begin
		next_state = state;
		case (state)
			CCS_ST_RESET: next_state = CCS_ST_CAPTURE;
			CCS_ST_CAPTURE: next_state = CCS_ST_BOOT;
			CCS_ST_BOOT: if (boot_start) next_state = CCS_ST_RUN;
			default: next_state = state;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= CCS_ST_RESET;
			strap <= 1'b0;
		end else begin
			state <= next_state;
			if (state == CCS_ST_CAPTURE) strap <= sel_s2;
		end
	end

	// ------------------------------------------------------------
	// APB decode.
	// ------------------------------------------------------------
	wire logic apb_access = psel && penable;
	wire logic apb_done = apb_access && pready;
	wire logic hit_slew = (paddr == `CCS_ADDR_SLEW);
	wire logic hit_src = (paddr == `CCS_ADDR_SRC);
	wire logic hit_st3 = (paddr == `CCS_ADDR_ST3);
	wire logic hit_boot = (paddr == `CCS_ADDR_BOOT);
	wire logic hit_any = hit_slew || hit_src || hit_st3 || hit_boot;
	wire logic wr_en = apb_done && pwrite && hit_any;
	wire logic boot_go = (state == CCS_ST_BOOT) && boot_start;

	logic [15:0] slew;
	ccs_src_t src;
	logic clk_off;
	logic [1:0] ref_idx;
	logic [31:0] rd_word;

	// Reads of unmapped words return zero with an error.
	always_comb begin
		rd_word = 32'h00000000;
		if (hit_slew) begin
			rd_word[15:0] = slew;
		end else if (hit_src) begin
			rd_word[1:0] = src;
		end else if (hit_st3) begin
			rd_word[`CCS_DIS_BIT] = clk_off;
		end else if (hit_boot) begin
			rd_word[1:0] = ref_idx;
			rd_word[`CCS_BYP_BIT] = pll_bypass;
			rd_word[`CCS_STRAP_BIT] = strap;
		end
	end

	// One wait state: ready rises in the second access cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_access && !pready;
			if (apb_access && !pready) begin
				prdata <= pwrite ? 32'h00000000 : rd_word;
				pslverr <= !hit_any;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------
	// The boot write of the disable bit wins over a software write in that cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			slew <= `CCS_SLEW_RST;
			src <= `CCS_SRC_RST;
			clk_off <= 1'b0;
			ref_idx <= `CCS_REFIDX_RST;
		end else begin
			if (wr_en && hit_slew) slew <= pwdata[15:0];
			if (wr_en && hit_src) src <= pwdata[1:0];
			if (wr_en && hit_boot) ref_idx <= pwdata[1:0];
			if (boot_go) begin
				clk_off <= 1'b1;
			end else if (wr_en && hit_st3) begin
				clk_off <= pwdata[`CCS_DIS_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Reference routing and internal clock taps.
	// ------------------------------------------------------------
	logic div2, div4;

	always_ff @(posedge clk) begin
		if (rst) begin
			gen_reference <= 1'b0;
			rtc_reference <= 1'b0;
			div2 <= 1'b0;
			div4 <= 1'b0;
		end else begin
			gen_reference <= strap ? ext_s2 : osc_s2;
			rtc_reference <= osc_s2;
			div2 <= !div2;
			div4 <= div4 ^ div2;
		end
	end

	// ------------------------------------------------------------
	// Boot clock assumptions.
	// ------------------------------------------------------------
	// Index 3 is unused and treated as the 12 MHz case.
	wire logic [31:0] ref_hz = (ref_idx == 2'h0) ? `CCS_REF0_HZ :
		(ref_idx == 2'h2) ? `CCS_REF2_HZ : `CCS_REF1_HZ;
	wire logic [31:0] spi_q = ref_hz / `CCS_SPI_HZ;
	wire logic [31:0] i2c_q = ref_hz / `CCS_I2C_HZ;
	wire logic [31:0] uart_q = ref_hz / `CCS_UART_BAUD;

	always_ff @(posedge clk) begin
		if (rst) begin
			pll_bypass <= 1'b0;
			spi_divider <= 8'h00;
			i2c_divider <= 8'h00;
			uart_divider <= 8'h00;
		end else if (boot_go) begin
			pll_bypass <= strap;
			spi_divider <= spi_q[7:0];
			i2c_divider <= i2c_q[7:0];
			uart_divider <= uart_q[7:0];
		end
	end

	// ------------------------------------------------------------
	// Debug clock pin.
	// ------------------------------------------------------------
	logic mux_q;

	ccs_debug_clock_output_mux u_mux (
		.clk(clk),
		.rst(rst),
		.src(src),
		.levels({div4, div2, osc_s2, gen_reference}),
		.level_q(mux_q)
	);

	// The pin is a sampled image of the source, so taps run at most half of clk.
	always_ff @(posedge clk) begin
		if (rst) begin
			debug_clock_output <= 1'b0;
			debug_clock_output_oe <= 1'b1;
			clock_out_slew_control_o <= `CCS_SLEW_RST;
		end else begin
			debug_clock_output <= clk_off ? 1'b0 : mux_q;
			debug_clock_output_oe <= !clk_off;
			clock_out_slew_control_o <= slew;
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_boot_go;
		(state == CCS_ST_BOOT) && boot_start;
	endsequence

	property p_src_route;
		(src == `CCS_SRC_OSC) && $stable(src) && !clk_off ##1 !clk_off |=> debug_clock_output == $past(osc_s2, 2);
	endproperty
	a_src_route: assert property (p_src_route) else $error("debug pin does not follow oscillator");

	property p_slew;
		apb_done && pwrite && hit_slew |-> ##2 clock_out_slew_control_o == $past(pwdata[15:0], 2);
	endproperty
	a_slew: assert property (p_slew) else $error("slew setting not applied");

	property p_float;
		clk_off |=> !debug_clock_output_oe && !debug_clock_output;
	endproperty
	a_float: assert property (p_float) else $error("debug pin driven while disabled");

	property p_boot_off;
		s_boot_go |=> clk_off ##1 !debug_clock_output_oe;
	endproperty
	a_boot_off: assert property (p_boot_off) else $error("boot did not float debug pin");

	property p_osc_ref;
		!strap && (state == CCS_ST_RUN) |=> gen_reference == $past(osc_s2) && rtc_reference == $past(osc_s2);
	endproperty
	a_osc_ref: assert property (p_osc_ref) else $error("oscillator reference not used");

	property p_ext_ref;
		strap && (state == CCS_ST_RUN) |=> gen_reference == $past(ext_s2) && rtc_reference == $past(osc_s2);
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("external reference not used");

	property p_bypass;
		s_boot_go ##0 strap |=> pll_bypass [*3];
	endproperty
	a_bypass: assert property (p_bypass) else $error("PLL not bypassed at boot");

	property p_rates;
		s_boot_go ##0 (ref_idx == 2'h0) |=> spi_divider == 8'd22 && i2c_divider == 8'd28 && uart_divider == 8'd196;
	endproperty
	a_rates: assert property (p_rates) else $error("boot serial rates wrong");

	property p_drive;
		!clk_off |=> debug_clock_output_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("debug pin not driven while enabled");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the clock source select and debug clock output block.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"
module testbench;
	import ccs_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic err;
	logic strap = 1'b1;
	logic boot_start = 1'b0;
	logic run = 1'b1;
	logic hold = 1'b0;
	wire logic ext_clk, osc_clk, pin, pin_oe, gen_ref, rtc_ref, bypass, pready, pslverr;
	wire logic [31:0] prdata;
	wire logic [15:0] slew_o;
	wire ccs_div_t spi_d, i2c_d, uart_d;
	int fails = 0;
	int n_tests = 0;

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	ccs_clock_partner u_partner (.run(run), .hold_level(hold), .ext_clk(ext_clk), .osc_clk(osc_clk));
	ccs_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_source_select(strap),
		.external_reference_clock_in(ext_clk), .osc_32k_in(osc_clk), .boot_start(boot_start),
		.debug_clock_output(pin), .debug_clock_output_oe(pin_oe), .clock_out_slew_control_o(slew_o),
		.gen_reference(gen_ref), .rtc_reference(rtc_ref), .pll_bypass(bypass), .spi_divider(spi_d),
		.i2c_divider(i2c_d), .uart_divider(uart_d));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; the request stays put until pready is seen at an edge.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
		if (i == 20) begin
			fails++;
			end_of_test();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The strap only changes under reset, never while the device runs.
	task do_reset(input logic sel);
		@(posedge clk);
		rst <= 1'b1;
		strap <= sel;
		cycles(6);
		rst <= 1'b0;
		cycles(4);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		chk(pin_oe, 1);
		apb(0, `CCS_ADDR_SLEW, 0);
		chk(rdata, `CCS_SLEW_RST);
		apb(0, `CCS_ADDR_SRC, 0);
		chk(rdata, `CCS_SRC_RST);
		apb(0, `CCS_ADDR_BOOT, 0);
		chk(rdata, 32'h21);
	endtask

	task t_regs;
		apb(1, `CCS_ADDR_SLEW, 32'hFFFF_A5C3);
		apb(0, `CCS_ADDR_SLEW, 0);
		chk(rdata, 32'h0000_A5C3);
		chk(slew_o, 16'hA5C3);
		apb(1, 16'h7080, 32'h1);
		apb(0, 16'h7080, 0);
		chk(rdata, 0);
		chk(err, 1);
		// Status bits of the boot word are read only; only the index takes the write.
		apb(1, `CCS_ADDR_BOOT, 32'h33);
		chk(err, 0);
		apb(0, `CCS_ADDR_BOOT, 0);
		chk(rdata, 32'h23);
	endtask

	// Parked sources give exact levels; divided sources are judged by rise counts.
	task t_src;
		int s, h, k;
		logic prev;
		run = 1'b0;
		for (h = 0; h < 2; h++) begin
			for (s = 0; s < 2; s++) begin
				hold = h[0];
				apb(1, `CCS_ADDR_SRC, s);
				cycles(25);
				chk(pin, s[0] ? !h[0] : h[0]);
				chk(gen_ref, h[0]);
				chk(rtc_ref, !h[0]);
			end
		end
		chk(pin_oe, 1);
		for (s = 2; s < 4; s++) begin
			apb(1, `CCS_ADDR_SRC, s);
			cycles(8);
			k = 0;
			prev = pin;
			repeat (40) begin
				@(posedge clk);
				if (pin === 1'b1 && prev === 1'b0)
					k++;
				prev = pin;
			end
			chk(k, (s == 2) ? 20 : 10);
		end
		run = 1'b1;
	endtask

	// The reference index is chosen before boot; rates follow the assumed frequency.
	task t_boot(input logic sel, input logic [1:0] r, input logic [31:0] boot_exp);
		logic [31:0] hz;
		hz = (r == 2'h0) ? `CCS_REF0_HZ : (r == 2'h2) ? `CCS_REF2_HZ : `CCS_REF1_HZ;
		apb(1, `CCS_ADDR_BOOT, {30'h0, r});
		@(posedge clk);
		boot_start <= 1'b1;
		@(posedge clk);
		boot_start <= 1'b0;
		cycles(3);
		chk(pin_oe, 0);
		chk(pin, 0);
		chk(bypass, sel);
		chk(spi_d, hz / `CCS_SPI_HZ);
		chk(i2c_d, hz / `CCS_I2C_HZ);
		chk(uart_d, hz / `CCS_UART_BAUD);
		apb(0, `CCS_ADDR_ST3, 0);
		chk(rdata, 1);
		apb(0, `CCS_ADDR_BOOT, 0);
		chk(rdata, boot_exp);
	endtask

	task t_enable;
		apb(1, `CCS_ADDR_ST3, 0);
		cycles(3);
		chk(pin_oe, 1);
		apb(1, `CCS_ADDR_ST3, 1);
		cycles(3);
		chk(pin_oe, 0);
	endtask

	// External input parked low, oscillator high: the generator must follow the oscillator.
	task t_strap_low;
		do_reset(1'b0);
		run = 1'b0;
		hold = 1'b0;
		cycles(30);
		chk(gen_ref, 1);
		chk(rtc_ref, 1);
		run = 1'b1;
		t_boot(1'b0, 2'h0, 32'h00);
	endtask

	// Main sequence.
	initial begin
		do_reset(1'b1);
		t_reset();
		t_regs();
		t_src();
		t_boot(1'b1, 2'h2, 32'h32);
		t_enable();
		t_strap_low();
		end_of_test();
	end
endmodule
`default_nettype wire
